// [dv/rxb_card_model.sv]
// Behavioural card that answers with bits, collisions and parity faults.
`timescale 1ns/1ps
module rxb_card_model
(
    input logic                 clk_sys,
    input logic                 rst,
    input logic                 go,
    input logic [63:0]          data,
    input logic [6:0]           nbits,
    input logic [6:0]           coll_at,
    input logic [6:0]           perr_at,
    input logic [1:0]           gap,
    output rxb_pkg::rxb_rx_ev_t ev,
    output logic                sof,
    output logic                busy
);
    import rxb_pkg::*;
    logic [6:0] idx_reg;  // Index of the next data bit.
    logic [1:0] wait_reg; // Idle cycles left before that bit.
    // One bit every gap+1 cycles; between bits the value line wanders so
    // that the receiver cannot lean on a stale level.
    always @(posedge clk_sys)
    begin
        ev           <= '0;
        ev.bit_value <= ~ev.bit_value | rst;
        sof          <= 1'b0;
        if (rst)
            busy <= 1'b0;
        else if (go)
        begin
            busy     <= 1'b1;
            sof      <= 1'b1;
            idx_reg  <= 7'h00;
            wait_reg <= gap;
        end
        else if (busy && wait_reg != 2'h0)
            wait_reg <= wait_reg - 2'h1;
        else if (busy && idx_reg == nbits)
        begin
            ev.frame_end <= 1'b1;
            busy         <= 1'b0;
        end
        else if (busy)
        begin
            ev.bit_valid  <= 1'b1;
            ev.bit_value  <= data[idx_reg[5:0]];
            ev.collision  <= idx_reg == coll_at;
            ev.parity_err <= idx_reg == perr_at;
            idx_reg       <= idx_reg + 7'h01;
            wait_reg      <= gap;
        end
    end
endmodule

// [dv/rxb_top_props.sv]
// Concurrent checks on the ports of the receive bit-control bank.
`timescale 1ns/1ps
module rxb_top_props
(
    input logic                clk_sys,
    input logic                rst,
    input logic                wb_cyc_i,
    input logic                wb_stb_i,
    input logic                wb_we_i,
    input logic [7:0]          wb_adr_i,
    input logic [3:0]          wb_sel_i,
    input logic [31:0]         wb_dat_o,
    input logic                wb_ack_o,
    input rxb_pkg::rxb_rx_ev_t rx_ev,
    input logic                card_authenticate_cmd,
    input logic                cipher_active,
    input rxb_pkg::rxb_byte_t  rx_byte,
    input logic                irq
);
    import rxb_pkg::*;
    // Byte address of the status register on the bus.
    localparam logic [7:0] A_STAT = {ADDR_STATUS_IDX[5:0], 2'b00};
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // A taken request is answered at the very next edge, and only once.
    req_ack_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    // Read data is zero outside ack, so a stale value cannot be mistaken.
    idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    auth_set_a: assert property (
        card_authenticate_cmd |=> cipher_active)
        else $error("cipher not set by authentication");
    cipher_cause_a: assert property (
        $rose(cipher_active) |-> $past(card_authenticate_cmd))
        else $error("cipher set without authentication");
    // Only a software write to the status register may drop the cipher.
    cipher_hold_a: assert property (
        cipher_active && !(wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
        wb_sel_i[0] && wb_adr_i == A_STAT) |=> cipher_active)
        else $error("cipher dropped without software clear");
    stat_code_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == A_STAT
        |=> wb_dat_o[2:0] != 3'h4 && wb_dat_o[7:6] == 2'h0 &&
        wb_dat_o[4:3] == 2'h0)
        else $error("bad status read");
    reset_quiet_a: assert property ($fell(rst) |-> !wb_ack_o && !irq &&
        !cipher_active && !rx_byte.valid)
        else $error("outputs active after reset");
endmodule
bind rxb_top rxb_top_props i_rxb_top_props (
    .clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_o, .wb_ack_o, .rx_ev, .card_authenticate_cmd, .cipher_active,
    .rx_byte, .irq);

// [dv/testbench.sv]
// Self-checking bench for the receive bit-control register bank.
`timescale 1ns/1ps
module testbench;
    import rxb_pkg::*;
    // One row: bit control, frame shape, then the expected report.
    typedef struct packed {
        logic [2:0]  align;
        logic        keep;
        logic        collision_as_integrity_error;
        logic [6:0]  nbits;
        logic [6:0]  coll;
        logic [6:0]  perr;
        logic [15:0] d;
        logic [7:0]  coll_exp;
        logic [7:0]  err_exp;
    } rxb_row_t;
    localparam rxb_row_t ROWS [7] = '{
        '{3'h0, 1'b0, 1'b0, 7'h0D, 7'h03, 7'h7F, 16'hA5C3, 8'h83, 8'h04},
        '{3'h4, 1'b1, 1'b1, 7'h04, 7'h03, 7'h7F, 16'h5A3C, 8'h87, 8'h05},
        '{3'h7, 1'b0, 1'b0, 7'h0C, 7'h7F, 7'h05, 16'hF0F1, 8'h00, 8'h01},
        '{3'h0, 1'b1, 1'b0, 7'h48, 7'h46, 7'h7F, 16'h1234, 8'h00, 8'h04},
        '{3'h0, 1'b0, 1'b0, 7'h48, 7'h3F, 7'h7F, 16'hFFFF, 8'hBF, 8'h04},
        '{3'h1, 1'b0, 1'b0, 7'h48, 7'h3F, 7'h7F, 16'hC3C3, 8'h00, 8'h04},
        '{3'h1, 1'b0, 1'b0, 7'h48, 7'h3E, 7'h7F, 16'hC3C3, 8'hBF, 8'h04}};
    localparam logic [5:0] STEPS [4] = '{6'h20, 6'h08, 6'h04, 6'h02};
    localparam logic [2:0] CODES [4] = '{ST_TXW, ST_TX, ST_RXW, ST_WAITD};
    localparam logic [7:0] A_STAT = {ADDR_STATUS_IDX[5:0], 2'b00};
    localparam logic [7:0] A_BIT  = {ADDR_BITCTL_IDX[5:0], 2'b00};
    localparam logic [7:0] A_COLL = {ADDR_COLL_IDX[5:0], 2'b00};
    localparam logic [7:0] A_ERR  = {ADDR_ERR_IDX[5:0], 2'b00};
    localparam logic [7:0] A_IST  = {ADDR_IRQST_IDX[5:0], 2'b00};
    localparam logic [7:0] A_IMSK = {ADDR_IRQMSK_IDX[5:0], 2'b00};
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [7:0]  adr     = 8'h00;
    logic [31:0] dat     = 32'h0;
    logic [3:0]  sel     = 4'h0;
    logic [5:0]  ctl     = 6'h00; // Engine steps and authentication.
    logic        go      = 1'b0;
    logic [63:0] cdata   = 64'h0;
    logic [6:0]  nbits   = 7'h00;
    logic [6:0]  coll    = 7'h7F;
    logic [6:0]  perr    = 7'h7F;
    logic [1:0]  gap     = 2'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic        sof;
    logic        busy;
    logic        cipher;
    logic        irq;
    rxb_rx_ev_t  ev;
    rxb_byte_t   rxb;
    logic [7:0]  got [$]; // Bytes stored during the current frame.
    int          fails = 0;
    int          compares = 0;
    rxb_top i_rxb_top (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
        .wb_dat_o(rdat), .wb_ack_o(ack), .start_tx(ctl[5]),
        .start_rx(ctl[4]), .tx_go(ctl[3]), .tx_done(ctl[2]),
        .rx_go(ctl[1]), .sof_seen(sof), .rx_ev(ev),
        .card_authenticate_cmd(ctl[0]), .cipher_active(cipher),
        .rx_byte(rxb), .irq(irq));
    rxb_card_model i_card (
        .clk_sys(clk_sys), .rst(rst), .go(go), .data(cdata),
        .nbits(nbits), .coll_at(coll), .perr_at(perr), .gap(gap),
        .ev(ev), .sof(sof), .busy(busy));
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        if (rxb.valid === 1'b1)
            got.push_back(rxb.data);
    task automatic end_sim();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [7:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h0, d};
        sel <= s;
        do
            @(posedge clk_sys);
        while (ack !== 1'b1 && ++k < 40);
        if (k >= 40)
            fails++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(a, 1'b1, d, 4'h1);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, 8'h00, 4'hF);
        check(q, e);
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clk_sys);
        ctl <= m;
        @(posedge clk_sys);
        ctl <= 6'h00;
    endtask
    task automatic launch(input logic [6:0] n, input logic [6:0] c,
                          input logic [1:0] g, input logic [15:0] d);
        @(posedge clk_sys);
        nbits <= n;
        coll  <= c;
        gap   <= g;
        cdata <= {4{d}};
        go    <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
    endtask
    // Waits out the frame, bounded, then lets the report registers land.
    task automatic settle();
        int k;
        k = 0;
        do
            @(posedge clk_sys);
        while (busy !== 1'b0 && ++k < 1000);
        if (k >= 1000)
            fails++;
        repeat (3) @(posedge clk_sys);
    endtask
    // First stored byte: mask in the upper half, value in the lower.
    function automatic logic [15:0] byte0(input rxb_row_t r);
        logic [15:0] v;
        v = 16'h0;
        for (int i = 0; i < 8; i++)
            if (i >= r.align && i - r.align < r.nbits)
            begin
                v[8 + i] = 1'b1;
                v[i] = r.d[i - r.align] & (r.keep | i - r.align < r.coll);
            end
        return v;
    endfunction
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        end_sim();
    end
    initial
    begin
        rxb_row_t    r;
        logic [15:0] m;
        logic [2:0]  lb;
        logic [31:0] msk;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            r   = ROWS[i];
            m   = byte0(r);
            lb  = (r.align == 3'h0) ? 3'h0 : 3'(r.align + r.nbits);
            msk = (r.coll_exp[7] || !r.err_exp[2]) ? 32'hFF : 32'h80;
            wr(A_BIT, {r.keep, r.align, r.collision_as_integrity_error, 3'h0});
            pulse(6'h10);
            got.delete();
            perr <= r.perr;
            launch(r.nbits, r.coll, 2'(i), r.d);
            settle();
            wb(A_COLL, 1'b0, 8'h00, 4'hF);
            check(q & msk, {24'h0, r.coll_exp});
            rdc(A_ERR, {24'h0, r.err_exp});
            rdc(A_BIT, {24'h0, r.keep, r.align, r.collision_as_integrity_error, lb});
            check(32'(got.size()), (32'(r.align) + r.nbits + 7) / 8);
            check({24'h0, got[0] & m[15:8]}, {24'h0, m[7:0]});
        end
        // Sticky events, masked level, write-one clear.
        rdc(A_IST, 32'h7);
        check({31'h0, irq}, 32'h0);
        wr(A_IMSK, 8'h02);
        @(posedge clk_sys);
        check({31'h0, irq}, 32'h1);
        wr(A_IST, 8'h02);
        @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        rdc(A_IST, 32'h5);
        for (int k = 0; k < 4; k++)
        begin
            pulse(STEPS[k]);
            rdc(A_STAT, {29'h0, CODES[k]});
        end
        rdc(A_ERR, 32'h0);
        rdc(A_COLL, 32'h0);
        rdc(A_BIT, 32'h10);
        perr <= 7'h7F;
        launch(7'h08, 7'h7F, 2'h3, 16'h00FF);
        rdc(A_STAT, {29'h0, ST_RX});
        settle();
        rdc(A_STAT, {29'h0, ST_IDLE});
        pulse(6'h01);
        rdc(A_STAT, 32'h20);
        wr(A_STAT, 8'h20);
        wb(A_STAT, 1'b1, 8'h00, 4'h0);
        rdc(A_STAT, 32'h20);
        wr(A_STAT, 8'h00);
        rdc(A_STAT, 32'h0);
        // Unmapped place and read-only report ignore writes.
        wr(8'hFC, 8'hFF);
        rdc(8'hFC, 32'h0);
        wr(A_COLL, 8'hFF);
        rdc(A_COLL, 32'h0);
        pulse(6'h01);
        wr(A_BIT, 8'hF5);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(A_BIT, {24'h0, RST_BITCTL});
        rdc(A_COLL, {24'h0, RST_COLL});
        rdc(A_STAT, 32'h0);
        end_sim();
    end
endmodule

// [logic/rxb_engine.sv]
// Transmit/receive engine state tracker for the receive bit-control bank.
`timescale 1ns/1ps
module rxb_engine
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             start_tx,
    input  wire logic             start_rx,
    input  wire logic             tx_go,
    input  wire logic             tx_done,
    input  wire logic             rx_go,
    input  wire logic             sof_seen,
    input  wire logic             frame_end,
    output logic [2:0]            state_code,
    output logic                  rx_start_pulse,
    output logic                  waitd_pulse
);
    import rxb_pkg::*;

    // All state of the engine.
    typedef struct packed {
        rxb_eng_t   eng;
    } rxb_eng_st_t;

    rxb_eng_st_t st_reg;
    rxb_eng_st_t st_next;

    // Next state: transceive walks every phase, receive jumps to waiting.
    always_comb
    begin
        st_next = st_reg;
        case (st_reg.eng)
            ENG_IDLE:
            begin
                if (start_tx)
                    st_next.eng = ENG_TXW;
                else if (start_rx)
                    st_next.eng = ENG_WAITD;
            end
            ENG_TXW:   if (tx_go)     st_next.eng = ENG_TX;
            ENG_TX:    if (tx_done)   st_next.eng = ENG_RXW;
            ENG_RXW:   if (rx_go)     st_next.eng = ENG_WAITD;
            ENG_WAITD: if (sof_seen)  st_next.eng = ENG_RX;
            ENG_RX:    if (frame_end) st_next.eng = ENG_IDLE;
            default:   st_next.eng = ENG_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            st_reg <= '{eng: ENG_IDLE};
        else
            st_reg <= st_next;
    end

    assign waitd_pulse = (st_next.eng == ENG_WAITD)
                         && (st_reg.eng != ENG_WAITD);
    // A reception starts on the same entry.
    assign rx_start_pulse = waitd_pulse;

    always_comb
    begin
        case (st_reg.eng)
            ENG_IDLE:  state_code = ST_IDLE;
            ENG_TXW:   state_code = ST_TXW;
            ENG_TX:    state_code = ST_TX;
            ENG_RXW:   state_code = ST_RXW;
            ENG_WAITD: state_code = ST_WAITD;
            ENG_RX:    state_code = ST_RX;
            default:   state_code = ST_IDLE;
        endcase
    end
endmodule

// [logic/rxb_packer.sv]
// Bit packer that aligns received bits into bytes.
`timescale 1ns/1ps
module rxb_packer
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             restart,
    input  wire logic [2:0]       align,
    input  wire logic             bit_valid,
    input  wire logic             bit_value,
    input  wire logic             flush,
    output rxb_pkg::rxb_byte_t    byte_out,
    output logic [2:0]            fill_pos
);
    import rxb_pkg::*;

    // All state of the packer.
    typedef struct packed {
        logic [2:0] pos;
        logic [7:0] acc;
        rxb_byte_t  out;
    } rxb_pk_st_t;

    rxb_pk_st_t st_reg;
    rxb_pk_st_t st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.out.valid = 1'b0;
        if (restart)
        begin
            st_next.pos = align;
            st_next.acc = 8'h00;
        end
        else if (bit_valid)
        begin
            st_next.acc[st_reg.pos] = bit_value;
            st_next.pos = st_reg.pos + 3'h1;
            // After bit 7 the byte is complete and the next wraps to 0.
            if (st_reg.pos == 3'h7)
            begin
                st_next.out.valid = 1'b1;
                st_next.out.data  = st_next.acc;
                st_next.acc       = 8'h00;
            end
        end
        else if (flush && (st_reg.pos != 3'h0))
        begin
            // A partial last byte is handed over as it stands.
            st_next.out.valid = 1'b1;
            st_next.out.data  = st_reg.acc;
            st_next.acc       = 8'h00;
        end
    end

    // State register.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign byte_out = st_reg.out;
    assign fill_pos = st_reg.pos;
endmodule

// [logic/rxb_pkg.sv]
// Package of constants and carrier types for the receive bit-control bank.
package rxb_pkg;
    // Word indices of the registers; the byte address is four times this.
    localparam logic [7:0] ADDR_STATUS_IDX = 8'h0B;
    localparam logic [7:0] ADDR_BITCTL_IDX = 8'h0C;
    localparam logic [7:0] ADDR_COLL_IDX   = 8'h0D;
    localparam logic [7:0] ADDR_ERR_IDX    = 8'h20;
    localparam logic [7:0] ADDR_IRQST_IDX  = 8'h21;
    localparam logic [7:0] ADDR_IRQMSK_IDX = 8'h22;
    // Field positions.
    localparam int POS_CIPHER   = 5;
    localparam int POS_KEEP     = 7;
    localparam int POS_ALIGN    = 4;
    localparam int POS_COLLISION_AS_INTEGRITY_ERROR   = 3;
    localparam int POS_CPVALID  = 7;
    localparam int POS_IERR     = 0;
    localparam int POS_CDET     = 2;
    // Reset values.
    localparam logic [7:0] RST_BITCTL = 8'h00;
    localparam logic [7:0] RST_COLL   = 8'h00;
    // Bound on the collision index, 64 bits; only indices below it are reportable.
    localparam logic [9:0] COLL_LIMIT = 10'h040;
    // Engine state codes as shown to software.
    localparam logic [2:0] ST_IDLE  = 3'h0;
    localparam logic [2:0] ST_TXW   = 3'h1;
    localparam logic [2:0] ST_TX    = 3'h3;
    localparam logic [2:0] ST_RXW   = 3'h5;
    localparam logic [2:0] ST_WAITD = 3'h6;
    localparam logic [2:0] ST_RX    = 3'h7;
    // Interrupt status bit positions.
    localparam int IRQ_COLL = 0;
    localparam int IRQ_IERR = 1;
    localparam int IRQ_DONE = 2;

    // Engine state, one-hot.
    typedef enum logic [5:0] {
        ENG_IDLE  = 6'h01,
        ENG_TXW   = 6'h02,
        ENG_TX    = 6'h04,
        ENG_RXW   = 6'h08,
        ENG_WAITD = 6'h10,
        ENG_RX    = 6'h20
    } rxb_eng_t;

    // Events from the receive decoder, one cycle each.
    typedef struct packed {
        logic       bit_valid;   // One data bit arrives.
        logic       bit_value;   // Its value.
        logic       collision;   // The bit collided.
        logic       parity_err;  // Parity or checksum mismatch.
        logic       frame_end;   // End of the received frame.
    } rxb_rx_ev_t;

    // Stored data byte towards the receive store.
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rxb_byte_t;
endpackage

// [logic/rxb_top.sv]
// Status, bit-framing and collision-report register bank on Wishbone.
// Contract
// - Cipher bit: software clears, authentication sets
// - State field encodes engine phase codes
// - Bits after collision become zero unless kept
// - Alignment field places first stored bit
// - Zero alignment byte mode, else bit mode
// - Collision raises integrity error when enabled
// - Last-byte bit count, zero means eight
// - Decoder writes count at end, cleared
// - Valid flag only for meaningful position
// - Position is zero-based first collided bit
// - Positions only within first eight bytes
// - Alignment offset added into reported position
// - Parity mismatch raises integrity error, continue
// - Collision flag cleared when reception starts
`timescale 1ns/1ps
module rxb_top
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             start_tx,
    input  wire logic             start_rx,
    input  wire logic             tx_go,
    input  wire logic             tx_done,
    input  wire logic             rx_go,
    input  wire logic             sof_seen,
    input  wire rxb_pkg::rxb_rx_ev_t rx_ev,
    input  wire logic             card_authenticate_cmd,
    output logic                  cipher_active,
    output rxb_pkg::rxb_byte_t    rx_byte,
    output logic                  irq
);
    import rxb_pkg::*;

    // Match of the bus address against a word index.
    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] idx);
        hit = (adr[7:2] == idx[5:0]) && (adr[1:0] == 2'h0);
    endfunction

    // All state of the bank.
    typedef struct packed {
        logic       ack;
        logic [31:0] rdata;
        logic       cipher;
        logic       keep;
        logic [2:0] align;
        logic       collision_as_integrity_error;
        logic [2:0] lastbits;
        logic       cp_valid;
        logic [6:0] cpos;
        logic       coll_seen;
        logic       after_coll;
        logic [9:0] bit_cnt;
        logic       integ_err;
        logic       coll_det;
        logic [2:0] irq_st;
        logic [2:0] irq_msk;
    } rxb_st_t;

    rxb_st_t st_reg;
    rxb_st_t st_next;

    logic [2:0] state_code;   // Engine phase code.
    logic       rx_start;     // Reception start pulse.
    logic       waitd;        // Waiting-for-data entry pulse.
    logic [2:0] fill_pos;     // Packer's next bit position.
    logic       stored_bit;   // Bit value after collision masking.
    logic       wr_acc;       // Write strobe this cycle.
    logic       rd_acc;       // Read strobe this cycle.
    logic       lane0;        // Low byte lane selected.
    logic [9:0] coll_index;   // Aligned index of the current bit.

    // Engine phase tracker.
    rxb_engine u_engine
    (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .start_tx       (start_tx),
        .start_rx       (start_rx),
        .tx_go          (tx_go),
        .tx_done        (tx_done),
        .rx_go          (rx_go),
        .sof_seen       (sof_seen),
        .frame_end      (rx_ev.frame_end),
        .state_code     (state_code),
        .rx_start_pulse (rx_start),
        .waitd_pulse    (waitd)
    );

    assign stored_bit = rx_ev.bit_value
        & (st_reg.keep | ~(st_reg.after_coll | rx_ev.collision));

    // Bit packer.
    rxb_packer u_packer
    (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .restart   (rx_start),
        .align     (st_reg.align),
        .bit_valid (rx_ev.bit_valid),
        .bit_value (stored_bit),
        .flush     (rx_ev.frame_end),
        .byte_out  (rx_byte),
        .fill_pos  (fill_pos)
    );

    // Bus strobes; only one answer per request, so ack is held low between.
    assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & ~st_reg.ack;
    assign rd_acc = wb_cyc_i & wb_stb_i & ~wb_we_i & ~st_reg.ack;
    assign lane0  = wb_sel_i[0];

    assign coll_index = st_reg.bit_cnt + {7'h00, st_reg.align};

    // Main next-state process: interrupt-status clear first, then decoder events,
    // other software writes last, with hardware sets winning over software clears.
    always_comb
    begin
        st_next = st_reg;
        st_next.ack = wb_cyc_i & wb_stb_i & ~st_reg.ack;

        // Write-one clear comes first, so an event in the same cycle
        // sets its bit again and is never lost.
        if (wr_acc && lane0 && hit(wb_adr_i, ADDR_IRQST_IDX))
            st_next.irq_st = st_reg.irq_st & ~wb_dat_i[2:0];

        if (rx_start)
        begin
            st_next.cp_valid   = 1'b0;
            st_next.cpos       = 7'h00;
            st_next.coll_seen  = 1'b0;
            st_next.after_coll = 1'b0;
            st_next.bit_cnt    = 10'h000;
            st_next.lastbits   = 3'h0;
            st_next.coll_det   = 1'b0;
            st_next.integ_err  = 1'b0;
        end

        if (rx_ev.bit_valid)
        begin
            st_next.bit_cnt = st_reg.bit_cnt + 10'h001;
            if (rx_ev.collision)
                st_next.after_coll = 1'b1;
        end

        if (rx_ev.bit_valid && rx_ev.collision && !st_reg.coll_seen)
        begin
            st_next.coll_seen = 1'b1;
            st_next.coll_det  = 1'b1;
            st_next.irq_st[IRQ_COLL] = 1'b1;
            if (coll_index < COLL_LIMIT)
            begin
                st_next.cp_valid = 1'b1;
                st_next.cpos = coll_index[6:0];
            end
        end

        if (rx_ev.bit_valid && rx_ev.collision && st_reg.collision_as_integrity_error)
        begin
            st_next.integ_err = 1'b1;
            st_next.irq_st[IRQ_IERR] = 1'b1;
        end

        if (rx_ev.parity_err)
        begin
            st_next.integ_err = 1'b1;
            st_next.irq_st[IRQ_IERR] = 1'b1;
        end

        if (rx_ev.frame_end)
        begin
            st_next.irq_st[IRQ_DONE] = 1'b1;
            if (st_reg.align != 3'h0)
                st_next.lastbits = fill_pos;
        end

        if (card_authenticate_cmd)
            st_next.cipher = 1'b1;

        if (wr_acc && lane0)
        begin
            if (hit(wb_adr_i, ADDR_STATUS_IDX))
            begin
                if (!wb_dat_i[POS_CIPHER] && !card_authenticate_cmd)
                    st_next.cipher = 1'b0;
            end
            else if (hit(wb_adr_i, ADDR_BITCTL_IDX))
            begin
                st_next.keep   = wb_dat_i[POS_KEEP];
                st_next.align  = wb_dat_i[POS_ALIGN +: 3];
                st_next.collision_as_integrity_error = wb_dat_i[POS_COLLISION_AS_INTEGRITY_ERROR];
                // A decoder update in the same cycle takes precedence.
                if (!(rx_ev.frame_end && st_reg.align != 3'h0) && !rx_start)
                    st_next.lastbits = wb_dat_i[2:0];
            end
            else if (hit(wb_adr_i, ADDR_IRQMSK_IDX))
                st_next.irq_msk = wb_dat_i[2:0];
        end

        // Read data is captured for the single-cycle answer.
        st_next.rdata = 32'h0000_0000;
        if (rd_acc)
        begin
            if (hit(wb_adr_i, ADDR_STATUS_IDX))
                st_next.rdata[7:0] = {2'h0, st_reg.cipher, 2'h0, state_code};
            else if (hit(wb_adr_i, ADDR_BITCTL_IDX))
                st_next.rdata[7:0] = {st_reg.keep, st_reg.align,
                                      st_reg.collision_as_integrity_error, st_reg.lastbits};
            else if (hit(wb_adr_i, ADDR_COLL_IDX))
                st_next.rdata[7:0] = {st_reg.cp_valid, st_reg.cpos};
            else if (hit(wb_adr_i, ADDR_ERR_IDX))
                st_next.rdata[7:0] = {5'h00, st_reg.coll_det, 1'b0,
                                      st_reg.integ_err};
            else if (hit(wb_adr_i, ADDR_IRQST_IDX))
                st_next.rdata[7:0] = {5'h00, st_reg.irq_st};
            else if (hit(wb_adr_i, ADDR_IRQMSK_IDX))
                st_next.rdata[7:0] = {5'h00, st_reg.irq_msk};
        end
    end

    // State register; control bits take their defined reset values.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_reg          <= '0;
            st_reg.keep     <= RST_BITCTL[POS_KEEP];
            st_reg.cpos     <= RST_COLL[6:0];
        end
        else
            st_reg <= st_next;
    end

    assign wb_ack_o      = st_reg.ack;
    assign wb_dat_o      = st_reg.rdata;
    assign cipher_active = st_reg.cipher;
    // The level interrupt follows masked sticky status.
    assign irq           = |(st_reg.irq_st & st_reg.irq_msk);
endmodule
